// ==== core/led_consts.svh ====
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

// ==========================================
// register offsets on the write port
`define REG_ENABLE     5'h00
`define REG_MAIN_LEVEL 5'h01
`define REG_BANK2      5'h02
`define REG_BANK3      5'h03
`define REG_FADE_RATE  5'h04

// ==========================================
// reset values and field layout
`define ENABLE_RST     5'h00
`define LEVEL_RST      5'h00
`define FADE_RST       8'h00
`define FADE_RATE_MSB  1
`define LOW_IQ_HALF_MA 6'h08

// ==========================================
// timing
`define CLK_HZ         100000000
`define CP_FREQ_HZ     250000
`define CP_HALF_CYC    (`CLK_HZ / (2 * `CP_FREQ_HZ))
`define FADE_STEP_US   1000
`define FADE_STEP_CYC  ((`FADE_STEP_US * (`CLK_HZ / 1000000)))
`define CP_HYST_US     20
`define CP_HYST_CYC    ((`CP_HYST_US * (`CLK_HZ / 1000000)))

`endif

// ==== core/led_pkg.sv ====
package led_pkg;
  typedef enum logic [1:0] {
    CP_1X  = 2'b00,
    CP_1X5 = 2'b01,
    CP_2X  = 2'b10
  } cp_mode_t;
endpackage

// ==== core/cp_ctrl.sv ====
`timescale 1ns/1ps
`include "led_consts.svh"

module cp_ctrl #(
  parameter int HYST_CYC = `CP_HYST_CYC,
  parameter int HALF_CYC = `CP_HALF_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              run,
  input  wire logic              headroom_low,
  input  wire logic              headroom_high,
  output led_pkg::cp_mode_t      cp_mode,
  output logic                   cp_clk
);
  // ==========================================
  // mode selection with hysteresis
  logic [15:0] dwell;
  logic [15:0] div;
  wire         up_req   = run && headroom_low && cp_mode != led_pkg::CP_2X;
  wire         down_req = run && headroom_high && cp_mode != led_pkg::CP_1X;
  wire         dwell_done = dwell >= 16'(HYST_CYC - 1);
  wire         switching  = run && cp_mode != led_pkg::CP_1X;
  wire         div_done   = div >= 16'(HALF_CYC - 1);

  // a condition must persist for the dwell time, so a brief dip cannot flip the mode back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cp_mode <= led_pkg::CP_1X;
      dwell   <= 16'h0000;
    end else if (ce) begin
      if (!run) begin
        cp_mode <= led_pkg::CP_1X;
        dwell   <= 16'h0000;
      end else if ((up_req || down_req) && !dwell_done) begin
        dwell <= dwell + 16'h0001;
      end else if (up_req) begin
        cp_mode <= (cp_mode == led_pkg::CP_1X) ? led_pkg::CP_1X5 : led_pkg::CP_2X;
        dwell   <= 16'h0000;
      end else if (down_req) begin
        cp_mode <= (cp_mode == led_pkg::CP_2X) ? led_pkg::CP_1X5 : led_pkg::CP_1X;
        dwell   <= 16'h0000;
      end else begin
        dwell <= 16'h0000;
      end
    end
  end

  // ==========================================
  // switching clock, silent in 1x and in sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div    <= 16'h0000;
      cp_clk <= 1'b0;
    end else if (ce) begin
      if (!switching) begin
        div    <= 16'h0000;
        cp_clk <= 1'b0;
      end else if (div_done) begin
        div    <= 16'h0000;
        cp_clk <= ~cp_clk;
      end else begin
        div <= div + 16'h0001;
      end
    end
  end
endmodule

// ==== core/led_sink_fade_control.sv ====
// How it works
// - code maps 0-25mA in 0.5/1/2mA steps
// - sink off by cleared enable or a code of 00h-03h
// - pump clock 250kHz in boost, stopped in 1x
// - least boost mode chosen, with hysteresis
// - sinks off and disabled after power-up
// - low quiescent flag at 4.0mA or below
// - five sinks grouped into three banks
// - only main bank fades, others immediate
// - fade steps each code per rate interval
// - new rate applies to remaining steps
// - new level retargets from present level
// - disabling fade jumps to final target
// - fade off means immediate level change
// - code zero is zero current
// - shutdown returns all registers to defaults
// - all sinks disabled means sleep, pump stopped
`timescale 1ns/1ps
`include "led_consts.svh"

module led_sink_fade_control #(
  parameter int SINKS         = 5,
  parameter int FADE_STEP_CYC = `FADE_STEP_CYC,
  parameter int CP_HYST_CYC   = `CP_HYST_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 shutdown,
  input  wire logic                 wr_en,
  input  wire logic [4:0]           wr_addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic [2*SINKS-1:0]   sink_bank,
  input  wire logic                 headroom_low,
  input  wire logic                 headroom_high,
  output logic      [SINKS-1:0]     sink_on,
  output logic      [6*SINKS-1:0]   sink_half_ma,
  output logic      [4:0]           main_level,
  output logic                      fading,
  output logic                      low_iq,
  output logic                      sleep,
  output led_pkg::cp_mode_t         cp_mode,
  output logic                      cp_clk
);
  // ==========================================
  // code to current, in half milliamps
  // codes 01h-03h sit below the first step and give no current
  function automatic logic [5:0] code_to_half_ma(input logic [4:0] code);
    logic [5:0] c;
    c = {1'b0, code};
    if (code < 5'h04) begin
      code_to_half_ma = 6'h00;
    end else if (code < 5'h0e) begin
      code_to_half_ma = c - 6'h03;
    end else if (code < 5'h1e) begin
      code_to_half_ma = 6'((c - 6'h0e) * 6'h02 + 6'h0c);
    end else begin
      code_to_half_ma = 6'((c - 6'h1e) * 6'h04 + 6'h2e);
    end
  endfunction

  // ==========================================
  // configuration registers
  logic [SINKS-1:0] enable;
  logic [4:0]       main_target;
  logic [4:0]       bank2_level;
  logic [4:0]       bank3_level;
  logic [7:0]       main_fade_rate;
  logic [31:0]      step_cnt;

  wire        wr_enable = wr_en && wr_addr == `REG_ENABLE;
  wire        wr_main   = wr_en && wr_addr == `REG_MAIN_LEVEL;
  wire        wr_bank2  = wr_en && wr_addr == `REG_BANK2;
  wire        wr_bank3  = wr_en && wr_addr == `REG_BANK3;
  wire        wr_rate   = wr_en && wr_addr == `REG_FADE_RATE;
  wire [1:0]  rate_sel  = main_fade_rate[`FADE_RATE_MSB:0];
  wire        fade_en   = rate_sel != 2'b00;
  wire [31:0] interval  = 32'(FADE_STEP_CYC) * {30'h0, rate_sel};
  // rate 0 gives interval 0 and the subtraction wraps; step_due is ignored then
  wire        step_due  = step_cnt >= interval - 32'h1;
  wire        at_target = main_level == main_target;

  // ==========================================
  // fade decode
  wire        wr_rate_off = wr_rate && wr_data[`FADE_RATE_MSB:0] == 2'b00;
  wire        step_up     = main_level < main_target;
  // no wrap: a step is only taken while the level differs from the target
  wire [4:0]  next_level  = step_up ? main_level + 5'h01 : main_level - 5'h01;

  // the fade state is fully reset by shutdown, as every register is
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable         <= SINKS'(`ENABLE_RST);
      main_target    <= `LEVEL_RST;
      bank2_level    <= `LEVEL_RST;
      bank3_level    <= `LEVEL_RST;
      main_fade_rate <= `FADE_RST;
    end else if (ce) begin
      if (shutdown) begin
        enable         <= SINKS'(`ENABLE_RST);
        main_target    <= `LEVEL_RST;
        bank2_level    <= `LEVEL_RST;
        bank3_level    <= `LEVEL_RST;
        main_fade_rate <= `FADE_RST;
      end else begin
        if (wr_enable) begin
          enable <= wr_data[SINKS-1:0];
        end
        if (wr_main) begin
          main_target <= wr_data[4:0];
        end
        if (wr_bank2) begin
          bank2_level <= wr_data[4:0];
        end
        if (wr_bank3) begin
          bank3_level <= wr_data[4:0];
        end
        if (wr_rate) begin
          main_fade_rate <= wr_data;
        end
      end
    end
  end

  // ==========================================
  // main bank fade sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      main_level <= `LEVEL_RST;
      step_cnt   <= 32'h0;
    end else if (ce) begin
      if (shutdown) begin
        main_level <= `LEVEL_RST;
        step_cnt   <= 32'h0;
      end else if (wr_main) begin
        step_cnt <= 32'h0;
        if (!fade_en) begin
          main_level <= wr_data[4:0];
        end
      end else if (wr_rate_off) begin
        main_level <= main_target;
        step_cnt   <= 32'h0;
      end else if (!fade_en || at_target) begin
        step_cnt <= 32'h0;
      end else if (step_due) begin
        step_cnt   <= 32'h0;
        main_level <= next_level;
      end else begin
        step_cnt <= step_cnt + 32'h1;
      end
    end
  end

  // ==========================================
  // bank routing and sink outputs
  wire [5:0] main_half_ma  = code_to_half_ma(main_level);
  wire [5:0] bank2_half_ma = code_to_half_ma(bank2_level);
  wire [5:0] bank3_half_ma = code_to_half_ma(bank3_level);
  wire [5:0] tgt_half_ma   = code_to_half_ma(main_target);

  genvar i;
  generate
    for (i = 0; i < SINKS; i = i + 1) begin : g_sink
      wire [1:0] bank = sink_bank[2*i +: 2];
      // bank code 3 is undefined and falls back to the main bank
      wire [5:0] bank_half_ma = (bank == 2'b01) ? bank2_half_ma :
                                (bank == 2'b10) ? bank3_half_ma : main_half_ma;
      wire       on_now       = enable[i] && bank_half_ma != 6'h00;
      wire [5:0] next_half_ma = on_now ? bank_half_ma : 6'h00;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sink_on[i]             <= 1'b0;
          sink_half_ma[6*i +: 6] <= 6'h00;
        end else if (ce) begin
          sink_on[i]             <= on_now;
          sink_half_ma[6*i +: 6] <= next_half_ma;
        end
      end
    end
  endgenerate

  // ==========================================
  // status decode
  // low_iq follows the stored target, not the faded level, so it cannot chatter mid-fade
  wire next_fading = fade_en && !at_target;
  wire next_low_iq = tgt_half_ma <= `LOW_IQ_HALF_MA;
  // sleep is judged on enables alone: enabled sinks at code zero still keep the pump awake
  wire next_sleep  = enable == '0;

  // ==========================================
  // status outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fading <= 1'b0;
      low_iq <= 1'b1;
      sleep  <= 1'b1;
    end else if (ce) begin
      fading <= next_fading;
      low_iq <= next_low_iq;
      sleep  <= next_sleep;
    end
  end


  // ==========================================
  // charge pump, run only while some sink is enabled
  cp_ctrl #(
    .HYST_CYC (CP_HYST_CYC),
    .HALF_CYC (`CP_HALF_CYC)
  ) u_cp (
    .mclk          (mclk),
    .rst           (rst),
    .ce            (ce),
    .run           (!sleep),
    .headroom_low  (headroom_low),
    .headroom_high (headroom_high),
    .cp_mode       (cp_mode),
    .cp_clk        (cp_clk)
  );
endmodule

// ==== verif/led_fade_monitor.sv ====
`timescale 1ns/1ps
// ===========
// port checker; shadows the enable, main level and fade rate registers
module led_fade_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        shutdown,
  input wire logic        wr_en,
  input wire logic [4:0]  wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic [9:0]  sink_bank,
  input wire logic        headroom_low,
  input wire logic        headroom_high,
  input wire logic [4:0]  sink_on,
  input wire logic [29:0] sink_half_ma,
  input wire logic [4:0]  main_level,
  input wire logic        fading,
  input wire logic        low_iq,
  input wire logic        sleep,
  input led_pkg::cp_mode_t cp_mode,
  input wire logic        cp_clk
);
  logic [4:0] en;
  logic [4:0] tgt;
  logic [1:0] rate;
  wire        wr    = ce && wr_en && !shutdown;
  wire        lvl   = wr && wr_addr == 5'h01;
  wire        rt    = wr && wr_addr == 5'h04;
  wire        quiet = ce && !wr_en && !shutdown;
  // shutdown clears like reset, so shadows follow the defaults
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || (ce && shutdown)) begin
      en   <= 5'h00;
      tgt  <= 5'h00;
      rate <= 2'h0;
    end else begin
      if (wr && wr_addr == 5'h00) en <= wr_data[4:0];
      if (lvl) tgt <= wr_data[4:0];
      if (rt) rate <= wr_data[1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ===========
  // assertions
  jump_now_a: assert property (lvl && rate == 2'h0 |-> ##2 main_level == tgt)
    else $error("level late");
  fade_abort_a: assert property (rt && wr_data[1:0] == 2'h0 |-> ##2 main_level == tgt)
    else $error("abort late");
  level_hold_a: assert property (quiet && main_level == tgt |=> $stable(main_level))
    else $error("level drifted");
  level_step_a: assert property ($changed(main_level) && rate != 2'h0 |->
    main_level - $past(main_level) == 5'h01 || $past(main_level) - main_level == 5'h01)
    else $error("step skipped");
  low_iq_a: assert property ($stable(tgt)[*3] |-> low_iq == (tgt <= 5'h0b))
    else $error("low iq wrong");
  sleep_flag_a: assert property ($stable(en)[*2] |-> sleep == (en == 5'h00))
    else $error("sleep wrong");
  pump_sleep_a: assert property (sleep[*3] |-> cp_mode == led_pkg::CP_1X && !cp_clk)
    else $error("pump awake");
  // a drop to 1x may cut a high phase short, which the pump allows
  pump_half_a: assert property ($rose(cp_clk) |-> ##199
    (cp_clk || sleep || cp_mode == led_pkg::CP_1X))
    else $error("half period short");
  mode_up_a: assert property (cp_mode > $past(cp_mode) |-> $past(headroom_low, 2)
    && $past(headroom_low, 4))
    else $error("mode up early");
  cover property (fading);
  cover property (cp_mode == led_pkg::CP_2X);
  cover property ($fell(sleep));
endmodule

bind led_sink_fade_control led_fade_monitor i_mon (.mclk, .rst, .ce, .shutdown, .wr_en,
  .wr_addr, .wr_data, .sink_bank, .headroom_low, .headroom_high, .sink_on, .sink_half_ma,
  .main_level, .fading, .low_iq, .sleep, .cp_mode, .cp_clk);

// ==== verif/led_host_model.sv ====
`timescale 1ns/1ps
// ===========
// host side of the already-decoded write port
module led_host_model (
  input  wire logic  mclk,
  output logic       wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data
);
  initial wr_en = 1'b0;
  initial wr_addr = 5'h1f;
  initial wr_data = 8'h00;
  // released lines show the inverse, never a stale copy
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  task automatic fade_in(input logic [4:0] en, input logic [7:0] lvl);
    put(5'h04, 8'h00);
    put(5'h01, 8'h04);
    put(5'h04, 8'h01);
    put(5'h00, {3'h0, en});
    put(5'h01, lvl);
  endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
// ===========
// bench
module tb;
  logic              mclk          = 1'b0;
  logic              rst           = 1'b1;
  logic              ce            = 1'b1;
  logic              shutdown      = 1'b0;
  logic              headroom_low  = 1'b0;
  logic              headroom_high = 1'b0;
  logic [9:0]        sink_bank     = 10'h024;
  wire               wr_en;
  wire  [4:0]        wr_addr;
  wire  [7:0]        wr_data;
  wire  [4:0]        sink_on;
  wire  [29:0]       sink_half_ma;
  wire  [4:0]        main_level;
  wire               fading, low_iq, sleep, cp_clk;
  led_pkg::cp_mode_t cp_mode;
  int                n_mismatch    = 0;
  int                total_checks  = 0;
  int                cycles        = 0;
  always #5 mclk = ~mclk;
  led_host_model i_host (.mclk, .wr_en, .wr_addr, .wr_data);
  led_sink_fade_control #(.FADE_STEP_CYC(4), .CP_HYST_CYC(4)) i_dut (.mclk, .rst, .ce,
    .shutdown, .wr_en, .wr_addr, .wr_data, .sink_bank, .headroom_low, .headroom_high,
    .sink_on, .sink_half_ma, .main_level, .fading, .low_iq, .sleep, .cp_mode, .cp_clk);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [7:0] half_ma(input logic [7:0] c);
    if (c < 8'h04) return 8'h00;
    if (c < 8'h0e) return c - 8'h03;
    if (c < 8'h1e) return c * 2 - 8'h10;
    return c * 4 - 8'h4a;
  endfunction
  // tests need about 750 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    cyc(6);
    rst = 1'b0;
    chk({sink_on, sleep}, 8'h01);
    $display("reset test done");
    i_host.put(5'h00, 8'h07);
    for (int c = 0; c < 32; c++) begin
      i_host.put(5'h01, 8'(c));
      cyc(2);
      chk(sink_half_ma[5:0], half_ma(8'(c)));
      chk(low_iq, c <= 11);
    end
    chk(sink_on, 8'h01);
    i_host.put(5'h00, 8'h06);
    i_host.put(5'h05, 8'h00);
    cyc(2);
    chk(sink_half_ma[5:0], 8'h00);
    i_host.put(5'h00, 8'h07);
    i_host.put(5'h04, 8'h01);
    i_host.put(5'h02, 8'h0e);
    i_host.put(5'h03, 8'h04);
    cyc(2);
    chk(sink_half_ma[17:6], 12'h04c);
    chk(main_level, 8'h1f);
    $display("code and bank test done");
    i_host.fade_in(5'h07, 8'h06);
    cyc(3);
    chk(main_level, 8'h04);
    cyc(1);
    chk(main_level, 8'h05);
    cyc(13);
    chk({fading, main_level}, 8'h06);
    i_host.put(5'h01, 8'h0a);
    cyc(5);
    i_host.put(5'h04, 8'h03);
    cyc(5);
    chk(main_level, 8'h07);
    i_host.put(5'h01, 8'h05);
    cyc(80);
    chk(main_level, 8'h05);
    i_host.put(5'h01, 8'h1a);
    cyc(20);
    chk(fading, 8'h01);
    i_host.put(5'h04, 8'h00);
    cyc(2);
    chk({fading, main_level}, 8'h1a);
    ce = 1'b0;
    i_host.put(5'h01, 8'h04);
    cyc(2);
    ce = 1'b1;
    cyc(2);
    chk(main_level, 8'h1a);
    $display("fade test done");
    shutdown = 1'b1;
    i_host.put(5'h00, 8'h1f);
    cyc(2);
    shutdown = 1'b0;
    cyc(2);
    chk({sink_on, sleep, main_level[1:0]}, 8'h04);
    $display("shutdown test done");
    i_host.put(5'h00, 8'h07);
    i_host.put(5'h01, 8'h1f);
    headroom_low = 1'b1;
    cyc(5);
    chk(cp_mode, 8'h01);
    cyc(4);
    chk(cp_mode, 8'h02);
    headroom_low = 1'b0;
    for (int i = 0; i < 250 && cp_clk !== 1'b0; i++) cyc(1);
    for (int i = 0; i < 250 && cp_clk !== 1'b1; i++) cyc(1);
    cyc(199);
    chk(cp_clk, 8'h01);
    cyc(1);
    chk(cp_clk, 8'h00);
    headroom_high = 1'b1;
    cyc(2);
    headroom_high = 1'b0;
    cyc(8);
    chk(cp_mode, 8'h02);
    headroom_high = 1'b1;
    cyc(5);
    chk(cp_mode, 8'h01);
    cyc(4);
    chk({cp_mode, cp_clk}, 8'h00);
    i_host.put(5'h00, 8'h00);
    cyc(4);
    chk({sleep, cp_mode, cp_clk}, 8'h08);
    $display("pump test done");
    tally_and_finish();
  end
endmodule
